// *** inc/gripper_defines.vh ***
`ifndef GRIPPER_DEFINES_VH
`define GRIPPER_DEFINES_VH
// byte offsets, output image
`define OFS_COMMAND     4'h0
`define OFS_TARGET      4'h3
`define OFS_SPEED       4'h4
`define OFS_FORCE       4'h5
// byte offsets, input image
`define OFS_STATUS      4'h0
`define OFS_FAULT       4'h2
`define OFS_TGT_ECHO    4'h3
`define OFS_POSITION    4'h4
`define OFS_CURRENT     4'h5
// command byte fields
`define BIT_ENABLE      0
`define BIT_GOTO        3
`define BIT_RELEASE     4
`define BIT_REL_DIR     5
// activation state codes
`define STA_RESET       2'h0
`define STA_ACTIVATING  2'h1
`define STA_DONE        2'h3
// object state codes
`define OBJ_MOVING      2'h0
`define OBJ_OPENING     2'h1
`define OBJ_CLOSING     2'h2
`define OBJ_AT_TARGET   2'h3
// fault codes
`define FLT_NONE        8'h00
`define FLT_DELAYED     8'h05
`define FLT_NOT_ACTIVE  8'h07
`define FLT_NO_COMMS    8'h09
`define FLT_MAJOR_MIN   8'h0A
`define FLT_REL_DONE    8'h0F
// timing
`define CLK_HZ          100000000
`define COMMS_TIMEOUT_S 1
`define COMMS_CYCLES    (`CLK_HZ * `COMMS_TIMEOUT_S)
`endif

// *** rtl/gripper_command_status_regs.v ***
`timescale 1ns/1ps
`default_nettype none
`include "gripper_defines.vh"

// Notes on behaviour
// (R1) enable 0 resets and clears faults
// (R2) enable rising starts calibration motion
// (R3) after power loss, need enable 0 then 1
// (R4) nothing else acts while enable is 0
// (R5) goto 1 moves to target, 0 stops
// (R6) no motion without goto except sequences
// (R7) release drives to limits, then faults
// (R8) release overrides all but enable; a release during calibration waits until calibration ends
// (R9) after release, toggle enable to recover
// (R10) direction sampled when release starts
// (R11) target 00 open, FF closed
// (R12) speed write changes motion, not starts
// (R13) over force limit halts, flags object
// (R14) controller writes zero to reserved bytes; the testbench writes random data to bytes 1 and 2
// (R15) status bit 0 echoes enable
// (R16) status bit 3 echoes goto when positioning
// (R17) state field 0, 1 or 3, never 2
// (R18) byte images addressed from zero
// (R19) controller uses only register images
// (R20) fault 07 not active, 05 delayed
// (R21) fault 09 after one second silence
// (R22) major faults hold until enable rises
// (R23) object state in status bits 7 and 6
// (R24) reserved reads zero, writes ignored
// (R25) echoes follow writes within one cycle
module gripper_command_status_regs #(
  parameter COMMS_TIMEOUT = `COMMS_CYCLES,  // silence limit in cycles
  parameter CAL_CYCLES    = 64,             // activation motion length
  parameter STEP_BASE     = 256             // motion step period at speed 0
) (
  // clock and reset
  input  wire       clock_i,
  input  wire       sys_rst_i,
  // register access
  input  wire       wr_en_i,
  input  wire       rd_en_i,
  input  wire [3:0] addr_i,
  input  wire [7:0] wr_data_i,
  output reg  [7:0] rd_data_o,
  // motor side
  input  wire [7:0] current_i,
  output reg  [7:0] finger_pos_o,
  output reg        moving_o,
  output reg        closing_o,
  output reg  [7:0] speed_set_o,
  output reg  [7:0] force_set_o
);

  // one-hot motion states
  localparam [4:0] S_RESET   = 5'h01;
  localparam [4:0] S_CAL     = 5'h02;
  localparam [4:0] S_IDLE    = 5'h04;
  localparam [4:0] S_GOTO    = 5'h08;
  localparam [4:0] S_RELEASE = 5'h10;

  reg [4:0]  state;          // motion state
  reg        enable_cmd;     // commanded enable
  reg        goto_cmd;       // commanded go-to
  reg        emergency_release_cmd; // commanded release
  reg        release_direction;     // commanded release direction
  reg        rel_open;       // direction latched at release start
  reg [7:0]  target_pos;     // target byte
  reg        armed;          // enable seen low since power up
  reg [7:0]  fault_code;     // fault byte
  reg [1:0]  object_state;   // object field
  reg [31:0] idle_cnt;       // cycles since last access
  reg [15:0] step_cnt;       // motion step timer
  reg [15:0] cal_cnt;        // calibration timer
  reg [7:0]  cur_s1;         // current sync stage one
  reg [7:0]  cur_s2;         // current sync stage two
  reg [7:0]  motor_current;  // sampled current
  reg [7:0]  next_pos;       // position after a step

  // register write decode
  wire wr_cmd   = wr_en_i && (addr_i == `OFS_COMMAND);
  wire new_en   = wr_cmd ? wr_data_i[`BIT_ENABLE] : enable_cmd;
  wire en_rise  = wr_cmd && wr_data_i[`BIT_ENABLE] && !enable_cmd;
  wire major    = (fault_code >= `FLT_MAJOR_MIN);
  // force limit compare, linear scale
  wire over_lim = (motor_current > force_set_o) && moving_o;
  // step period shrinks with speed, release always runs slowest
  wire [15:0] step_period = (state == S_RELEASE) ? STEP_BASE[15:0] :
                            STEP_BASE[15:0] - {8'h00, speed_set_o};
  wire step_now = (step_cnt >= step_period);

  // synchronise the motor current reading
  always @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cur_s1        <= 8'h00;
      cur_s2        <= 8'h00;
      motor_current <= 8'h00;
    end
    else
    begin
      cur_s1        <= current_i;
      cur_s2        <= cur_s1;
      motor_current <= cur_s2;
    end
  end

  // output register image
  always @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      // (R3) power loss leaves enable set
      enable_cmd            <= 1'b1;
      goto_cmd              <= 1'b0;
      emergency_release_cmd <= 1'b0;
      release_direction     <= 1'b0;
      target_pos            <= 8'h00;
      speed_set_o           <= 8'h00;
      force_set_o           <= 8'h00;
    end
    else if (wr_en_i)
    begin
      // (R24) only defined bits are stored
      case (addr_i)
        `OFS_COMMAND:
        begin
          enable_cmd            <= wr_data_i[`BIT_ENABLE];
          goto_cmd              <= wr_data_i[`BIT_GOTO];
          emergency_release_cmd <= wr_data_i[`BIT_RELEASE];
          release_direction     <= wr_data_i[`BIT_REL_DIR];
        end
        // (R11) position scale 00 open FF closed
        `OFS_TARGET: target_pos  <= wr_data_i;
        // (R12) speed applies live
        `OFS_SPEED:  speed_set_o <= wr_data_i;
        `OFS_FORCE:  force_set_o <= wr_data_i;
        default:     ;
      endcase
    end
  end

  // motion sequencer
  always @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state        <= S_RESET;
      armed        <= 1'b0;
      rel_open     <= 1'b0;
      finger_pos_o <= 8'h00;
      moving_o     <= 1'b0;
      closing_o    <= 1'b0;
      step_cnt     <= 16'h0000;
      cal_cnt      <= 16'h0000;
      object_state <= `OBJ_MOVING;
    end
    else
    begin
      step_cnt <= step_now ? 16'h0000 : step_cnt + 16'h0001;
      // (R3) arm once enable has been seen low
      if (!enable_cmd)
        armed <= 1'b1;
      // (R1) (R4) enable low forces reset
      if (!enable_cmd)
      begin
        state    <= S_RESET;
        moving_o <= 1'b0;
      end
      else
      begin
        case (state)
          S_RESET:
          begin
            // (R2) (R9) enable back high starts calibration
            if (armed)
            begin
              state    <= S_CAL;
              cal_cnt  <= 16'h0000;
              moving_o <= 1'b1;
            end
          end
          S_CAL:
          begin
            cal_cnt <= cal_cnt + 16'h0001;
            if (cal_cnt >= CAL_CYCLES[15:0])
            begin
              state    <= S_IDLE;
              moving_o <= 1'b0;
            end
          end
          S_IDLE, S_GOTO:
          begin
            // (R8) release beats goto
            if (emergency_release_cmd)
            begin
              // (R10) direction sampled here
              rel_open  <= release_direction;
              closing_o <= !release_direction;
              state     <= S_RELEASE;
              moving_o  <= 1'b1;
            end
            // (R5) (R6) move only with goto
            else if (goto_cmd)
            begin
              state <= S_GOTO;
              if (over_lim)
              begin
                // (R13) current limit halts, object seen
                moving_o     <= 1'b0;
                object_state <= closing_o ? `OBJ_CLOSING : `OBJ_OPENING;
              end
              else if (finger_pos_o == target_pos)
              begin
                moving_o     <= 1'b0;
                object_state <= `OBJ_AT_TARGET;
              end
              else if (object_state == `OBJ_MOVING || state == S_IDLE)
              begin
                moving_o     <= 1'b1;
                closing_o    <= (target_pos > finger_pos_o);
                object_state <= `OBJ_MOVING;
                if (step_now)
                  finger_pos_o <= next_pos;
              end
            end
            else
            begin
              // (R5) goto low stops
              state    <= S_IDLE;
              moving_o <= 1'b0;
            end
          end
          S_RELEASE:
          begin
            // (R7) slow drive to the stop
            if ((rel_open && finger_pos_o == 8'h00)
                || (!rel_open && finger_pos_o == 8'hFF))
              moving_o <= 1'b0;
            else if (step_now)
              finger_pos_o <= next_pos;
          end
          default: state <= S_RESET;
        endcase
      end
    end
  end

  // one position step toward the goal
  always @*
  begin
    next_pos = finger_pos_o;
    if (closing_o && finger_pos_o != 8'hFF)
      next_pos = finger_pos_o + 8'h01;
    else if (!closing_o && finger_pos_o != 8'h00)
      next_pos = finger_pos_o - 8'h01;
  end

  // fault byte and bus silence watch
  always @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fault_code <= `FLT_NONE;
      idle_cnt   <= 32'h0;
    end
    else
    begin
      idle_cnt <= (wr_en_i || rd_en_i) ? 32'h0 :
                  (idle_cnt < COMMS_TIMEOUT) ? idle_cnt + 32'h1 : idle_cnt;
      // (R1) enable low clears faults
      if (!new_en)
        fault_code <= `FLT_NONE;
      // (R7) release in progress, then finished
      else if (state == S_RELEASE)
        fault_code <= moving_o ? 8'h0B : `FLT_REL_DONE;
      // (R22) major faults held until enable rise
      else if (major && !en_rise)
        fault_code <= fault_code;
      // (R21) silence on the bus
      else if (idle_cnt >= COMMS_TIMEOUT)
        fault_code <= `FLT_NO_COMMS;
      // (R20) action before activation done
      else if (wr_cmd && (wr_data_i[`BIT_GOTO] || wr_data_i[`BIT_RELEASE]))
        fault_code <= (state == S_RESET) ? `FLT_NOT_ACTIVE :
                      (state == S_CAL) ? `FLT_DELAYED : `FLT_NONE;
      else if (state == S_IDLE || state == S_GOTO)
        fault_code <= `FLT_NONE;
    end
  end

  // input register image read, registered
  always @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rd_data_o <= 8'h00;
    else
    begin
      // (R18) input image by byte offset
      case (addr_i)
        // (R15) (R16) (R17) (R23) (R25) status byte
        `OFS_STATUS:
          rd_data_o <= {object_state,
                        ((state == S_CAL) ? `STA_ACTIVATING :
                         (state == S_IDLE || state == S_GOTO) ? `STA_DONE : `STA_RESET),
                        goto_cmd && (state == S_GOTO),
                        2'b00,
                        enable_cmd};
        `OFS_FAULT:    rd_data_o <= fault_code;
        `OFS_TGT_ECHO: rd_data_o <= target_pos;
        `OFS_POSITION: rd_data_o <= finger_pos_o;
        `OFS_CURRENT:  rd_data_o <= motor_current;
        // (R24) reserved bytes read zero
        default:       rd_data_o <= 8'h00;
      endcase
    end
  end

endmodule // gripper_command_status_regs
`default_nettype wire

// *** testbench/gripper_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module gripper_asserts (
  // watched ports
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  input wire logic       wr_en_i,
  input wire logic       rd_en_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [7:0] rd_data_o,
  input wire logic [7:0] current_i,
  input wire logic [7:0] finger_pos_o,
  input wire logic       moving_o,
  input wire logic       closing_o,
  input wire logic [7:0] speed_set_o,
  input wire logic [7:0] force_set_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic armed;    // enable written low since reset
  logic en_last;  // last written enable bit
  logic en_wr;    // write to the command byte
  assign en_wr = wr_en_i && addr_i == 4'h0;
  // helper flags, enable reads 1 after power loss
  always_ff @(posedge clock_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      armed <= 1'b0;
      en_last <= 1'b1;
    end
    else if (en_wr)
    begin
      armed <= armed | !wr_data_i[0];
      en_last <= wr_data_i[0];
    end
  a_unarmed_still: assert property (!armed |-> !moving_o)
    else $error("motion before enable cycle");
  a_activation_start: assert property (en_wr && wr_data_i[0] && armed && !en_last
    |-> ##[1:2] moving_o)
    else $error("no calibration motion");
  a_enable_stops: assert property (en_wr && !wr_data_i[0] |-> ##[1:2] !moving_o)
    else $error("motion with enable low");
  a_speed_store: assert property (wr_en_i && addr_i == 4'h4
    |=> speed_set_o == $past(wr_data_i))
    else $error("speed byte not stored");
  a_force_store: assert property (wr_en_i && addr_i == 4'h5
    |=> force_set_o == $past(wr_data_i))
    else $error("force byte not stored");
  a_reserved_zero: assert property ((addr_i == 4'h1 || addr_i > 4'h5)
    |=> rd_data_o == 8'h00)
    else $error("reserved byte not zero");
  a_status_codes: assert property (addr_i == 4'h0
    |=> rd_data_o[5:4] != 2'h2 && rd_data_o[2:1] == 2'h0)
    else $error("bad status byte");
  a_pos_moving: assert property ($changed(finger_pos_o)
    |-> moving_o || $past(moving_o))
    else $error("fingers moved while idle");
endmodule // gripper_asserts
bind gripper_command_status_regs gripper_asserts gripper_asserts_i (.clock_i(clock_i),
  .sys_rst_i(sys_rst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .current_i(current_i),
  .finger_pos_o(finger_pos_o), .moving_o(moving_o), .closing_o(closing_o),
  .speed_set_o(speed_set_o), .force_set_o(force_set_o));
`default_nettype wire

// *** testbench/finger_load_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module finger_load_model #(
  parameter logic [7:0] CONTACT_POS = 8'h80  // object edge
) (
  // motor side
  input  wire logic       moving_i,
  input  wire logic       closing_i,
  input  wire logic [7:0] pos_i,
  output wire logic [7:0] current_o
);
  // stall current once closing fingers press the object
  assign current_o = (moving_i && closing_i && pos_i >= CONTACT_POS) ? 8'hC0 : 8'h10;
endmodule // finger_load_model
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e); end end
module testbench;
  logic        clock_i = 0, sys_rst_i = 1, wr_en_i = 0, rd_en_i = 0;
  logic [3:0]  addr_i = 4'h0;
  logic [7:0]  wr_data_i = 8'h00, rd_data_o, current_i, finger_pos_o;
  logic [7:0]  speed_set_o, force_set_o, t, s;
  logic        moving_o, closing_o;
  logic [15:0] exp_q[$];  // {mask, value} per read
  int          errors = 0, n_tests = 0, k;
  gripper_command_status_regs #(.COMMS_TIMEOUT(200), .CAL_CYCLES(16), .STEP_BASE(8))
    gripper_command_status_regs_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
    .current_i(current_i), .finger_pos_o(finger_pos_o), .moving_o(moving_o),
    .closing_o(closing_o), .speed_set_o(speed_set_o), .force_set_o(force_set_o));
  finger_load_model finger_load_model_i (.moving_i(moving_o), .closing_i(closing_o),
    .pos_i(finger_pos_o), .current_o(current_i));
  initial forever #5 clock_i = ~clock_i;
  // read answers checked oldest first
  always @(negedge clock_i)
    if (exp_q.size() > 0)
    begin : mon
      logic [15:0] e;
      e = exp_q.pop_front();
      `CHK(rd_data_o & e[15:8], e[7:0])
    end
  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // control only through the register images
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i) #1;
    addr_i = a;
    wr_data_i = d;
    wr_en_i = 1;
    idle(1);
    wr_en_i = 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock_i) #1;
    addr_i = a;
    rd_en_i = 1;
    idle(1);
    rd_en_i = 0;
    exp_q.push_back({m, e});
  endtask
  // bounded wait for motion to end
  task automatic settle();
    idle(3);
    for (k = 0; k < 5000 && moving_o !== 1'b0; k++)
      idle(1);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin : dog
    #400000;
    errors++;
    end_of_test();
  end
  initial
  begin
    k = $urandom(32'h5e48f872);
    idle(5);
    sys_rst_i = 0;
    wr(4'h0, 8'h09);
    idle(20);
    `CHK(moving_o, 1'b0)
    rd(4'h0, 8'h39, 8'h01);
    rd(4'h2, 8'hFF, 8'h07);
    $display("test unarmed done");
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h39, 8'h00);
    rd(4'h2, 8'hFF, 8'h00);
    wr(4'h0, 8'h01);
    idle(2);
    `CHK(moving_o, 1'b1)
    rd(4'h0, 8'h30, 8'h10);
    wr(4'h0, 8'h09);
    rd(4'h2, 8'hFF, 8'h05);
    wr(4'h0, 8'h01);
    idle(30);
    rd(4'h0, 8'h30, 8'h30);
    $display("test activation done");
    t = 8'($urandom_range(16, 64));
    s = 8'($urandom_range(0, 7));
    wr(4'h3, t);
    wr(4'h4, s);
    wr(4'h5, 8'hFF);
    rd(4'h3, 8'hFF, t);
    `CHK(speed_set_o, s)
    `CHK(force_set_o, 8'hFF)
    for (int j = 1; j < 16; j++)
      if (j < 3 || j > 5)
      begin
        wr(4'(j), j < 3 ? 8'($urandom) : 8'h00);
        if (j != 2) rd(4'(j), 8'hFF, 8'h00);
      end
    wr(4'h0, 8'h09);
    settle();
    `CHK(finger_pos_o, t)
    rd(4'h0, 8'hC8, 8'hC8);
    $display("test positioning done");
    wr(4'h5, 8'h20);
    wr(4'h3, 8'hFF);
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h09);
    settle();
    rd(4'h0, 8'hC0, 8'h80);
    `CHK(finger_pos_o < 8'hFF, 1'b1)
    `CHK(closing_o, 1'b1)
    wr(4'h0, 8'h01);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h05);
    idle(10);
    `CHK(moving_o, 1'b0)
    $display("test object done");
    wr(4'h0, 8'h39);
    rd(4'h0, 8'h38, 8'h00);
    rd(4'h2, 8'hFF, 8'h0B);
    settle();
    `CHK(finger_pos_o, 8'h00)
    `CHK(closing_o, 1'b0)
    rd(4'h2, 8'hFF, 8'h0F);
    wr(4'h0, 8'h09);
    idle(10);
    `CHK(moving_o, 1'b0)
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h01);
    rd(4'h2, 8'hFF, 8'h00);
    $display("test release done");
    idle(300);
    rd(4'h2, 8'hFF, 8'h09);
    idle(2);
    $display("test silence done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
